// [logic/plc_dispatch_regs.svh]
// Offsets, field positions, reset values and timing counts of the
// interrupt task dispatcher.
// Assumes inclusion by bare name from the dispatcher design files.
`ifndef PLC_DISPATCH_REGS_SVH
`define PLC_DISPATCH_REGS_SVH

// Setup words on the configuration port
`define TB_SETUP_ADDR 8'hC3
`define PWR_SETUP_ADDR 8'hE1
`define TB_RESET 16'h0000
`define PWR_RESET 16'h0000
`define TB_FIELD_MSB 3
`define PWR_EN_BIT 15
`define PWR_DLY_MSB 7
`define PWR_DLY_MAX 8'h0A

// Time base codes
`define TB_CODE_10MS 4'h0
`define TB_CODE_1MS 4'h1
`define TB_CODE_100US 4'h2

// Timing: fine tick of 0.1 ms, 10 fine ticks per ms
`define CLK_PERIOD_NS 10
`define FINE_TICK_NS 100000
`define MS_NS 1000000
`define TICKS_10MS 7'h64
`define TICKS_1MS 7'h0A
`define TICKS_100US 7'h01
`define PWR_DEFAULT_MS 10

// Interrupt numbers of the mask-setting operation
`define MASK_MOD0_NUM 8'h00
`define MASK_MOD1_NUM 8'h01
`define PER0_NUM 8'h04
`define PER1_NUM 8'h05
`define MASK_RESET 32'hFFFFFFFF

// Task numbers
`define PWR_TASK 8'h01
`define PER0_TASK 8'h02
`define PER1_TASK 8'h03
`define IO_TASK_BASE 8'h64
`define IO_INPUTS 32

`endif

// [logic/plc_dispatch_pkg.sv]
// Types shared by the interrupt task dispatcher files.
// Assumes nothing beyond a SystemVerilog compiler.
package plc_dispatch_pkg;

  typedef enum logic [1:0] {
    TB_10MS,
    TB_1MS,
    TB_100US
  } tb_unit_e;

  typedef enum {
    ST_IDLE,
    ST_LOOK,
    ST_CHECK,
    ST_RUN,
    ST_HALT
  } disp_state_e;

  // External request as presented by a rack module
  typedef struct packed {
    logic [2:0] slot;
    logic [7:0] num;
  } ext_req_s;

  // Command towards the task execution engine
  typedef struct packed {
    logic start;
    logic abort;
    logic [7:0] num;
  } task_cmd_s;

endpackage : plc_dispatch_pkg

// [logic/task_table_mem.sv]
// Table of which of the 256 interrupt tasks exist in the program.
// Assumes writes from program load logic on the same clock.
`timescale 1ns/10ps
module task_table_mem (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic wbit_i,
  input wire logic [7:0] raddr_i,
  output logic rdata_o
);

  logic [255:0] mem_ff;
  logic [255:0] nxt_mem;
  logic rd_ff;
  logic nxt_rd;

  // Read returns the old entry on a same-cycle write
  always_comb begin
    nxt_mem = mem_ff;
    if (we_i) begin
      nxt_mem[waddr_i] = wbit_i;
    end
    nxt_rd = mem_ff[raddr_i];
  end

  // Cleared at reset so that no task counts as present
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ff <= '0;
      rd_ff <= 1'b0;
    end else begin
      mem_ff <= nxt_mem;
      rd_ff <= nxt_rd;
    end
  end

  assign rdata_o = rd_ff;

endmodule : task_table_mem

// [logic/periodic_timer.sv]
// One periodic interrupt timer: time base prescaler and interval count.
// Assumes a one-cycle fine tick every 0.1 ms from the parent.
`timescale 1ns/10ps
module periodic_timer
  import plc_dispatch_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fine_tick_i,
  input wire tb_unit_e unit_i,
  input wire logic [15:0] interval_i,
  input wire logic run_i,
  output logic fire_o
);

`include "plc_dispatch_regs.svh"

  logic [6:0] pre_ff;
  logic [6:0] nxt_pre;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic fire_ff;
  logic nxt_fire;
  logic [6:0] lim;

  // Interval is interval_i units of the selected base
  always_comb begin
    nxt_pre = pre_ff;
    nxt_cnt = cnt_ff;
    nxt_fire = 1'b0;
    unique case (unit_i)
      TB_1MS: lim = `TICKS_1MS;
      TB_100US: lim = `TICKS_100US;
      default: lim = `TICKS_10MS;
    endcase
    if (!run_i) begin
      nxt_pre = '0;
      nxt_cnt = '0;
    end else if (fine_tick_i) begin
      if (pre_ff >= lim - 7'h01) begin
        nxt_pre = '0;
        if (cnt_ff >= interval_i - 16'h0001) begin // R12
          nxt_cnt = '0;
          nxt_fire = 1'b1; // R10
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end else begin
        nxt_pre = pre_ff + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_ff <= '0;
      cnt_ff <= '0;
      fire_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      fire_ff <= nxt_fire;
    end
  end

  assign fire_o = fire_ff;

endmodule : periodic_timer

// [logic/plc_interrupt_task_dispatcher.sv]
// Interrupt task dispatcher: gathers input, periodic, power-loss and
// external requests and starts numbered interrupt tasks one at a time.
// Assumes pins from outside the clock domain and a task engine on clk_i
// that pulses task_done_i when a started task ends.
`timescale 1ns/10ps

// Function
// R1 - Interrupt task may start anytime in scan
// R2 - Enabled input reading ON dispatches its task
// R3 - Module inputs map to tasks 100-131
// R4 - Input interrupts disabled until mask set
// R5 - Mask bits 0-15 match inputs 0-15
// R6 - Mask bit zero enables, one masks
// R7 - Missing task on fire: fatal error, halt
// R8 - Periodic numbers 4,5 dispatch tasks 2,3
// R9 - Periodic disabled until interval and base set; code needs only a nonzero interval, base resets to 10ms
// R10 - Enabled periodic dispatches at fixed interval
// R11 - Time base codes 10ms, 1ms, 0.1ms
// R12 - Interval equals count times time base
// R13 - Power loss dispatches task 1 after delay
// R14 - Power task finishes within 10ms minus delay
// R15 - External requests 0-255 always enabled
// R16 - Requests from slots beyond limit ignored
// R17 - Duplex configuration disables all dispatch
// R18 - Shared number dispatches one same task
// R19 - Power loss terminates running task, no resume
// R20 - Interrupts during task wait until finish
// R21 - Power task enable bit and delay field
module plc_interrupt_task_dispatcher
  import plc_dispatch_pkg::*;
#(
  parameter int FINE_TICK_CYC = 100000 / 10,
  parameter int MAX_SLOT = 4,
  parameter int FAST_TB_EN = 1,
  parameter int PWR_DEFAULT_MS = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  input wire logic mask_op_i,
  input wire logic [7:0] mask_op_num_i,
  input wire logic [15:0] mask_op_data_i,
  input wire logic task_tbl_we_i,
  input wire logic [7:0] task_tbl_addr_i,
  input wire logic task_tbl_bit_i,
  input wire logic [31:0] io_irq_i,
  input wire logic ext_req_valid_i,
  input wire ext_req_s ext_req_i,
  input wire logic power_fail_i,
  input wire logic duplex_mode_i,
  input wire logic task_done_i,
  output task_cmd_s task_cmd_o,
  output logic busy_o,
  output logic fatal_error_o,
  output logic [7:0] fatal_task_o
);

`include "plc_dispatch_regs.svh"

  localparam int SW = 46;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic [SW-1:0] sync3_ff;
  logic [31:0] io_s;
  logic [31:0] io_prev;
  logic ext_v_s;
  logic ext_v_prev;
  ext_req_s ext_s;
  logic pwr_s;
  logic duplex_s;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // All pins pass two flops; the third stage only feeds edge detection
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= {duplex_mode_i, power_fail_i, ext_req_i,
                   ext_req_valid_i, io_irq_i};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  assign io_s = sync2_ff[31:0];
  assign io_prev = sync3_ff[31:0];
  assign ext_v_s = sync2_ff[32];
  assign ext_v_prev = sync3_ff[32];
  assign ext_s = sync2_ff[43:33];
  assign pwr_s = sync2_ff[44];
  assign duplex_s = sync2_ff[45];

  // Setup words, masks and periodic intervals
  logic [15:0] tb_reg_ff, nxt_tb_reg;
  logic [15:0] pwr_reg_ff, nxt_pwr_reg;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [31:0] mask_ff, nxt_mask;
  logic [15:0] ival0_ff, nxt_ival0;
  logic [15:0] ival1_ff, nxt_ival1;
  tb_unit_e unit;

  always_comb begin
    nxt_tb_reg = tb_reg_ff;
    nxt_pwr_reg = pwr_reg_ff;
    nxt_mask = mask_ff;
    nxt_ival0 = ival0_ff;
    nxt_ival1 = ival1_ff;
    nxt_rdata = 16'h0000; // Unmapped words read as zero
    if (cfg_we_i && cfg_addr_i == `TB_SETUP_ADDR) begin
      nxt_tb_reg = cfg_wdata_i;
    end
    if (cfg_we_i && cfg_addr_i == `PWR_SETUP_ADDR) begin
      nxt_pwr_reg = cfg_wdata_i; // R21
    end
    if (cfg_addr_i == `TB_SETUP_ADDR) begin
      nxt_rdata = tb_reg_ff;
    end else if (cfg_addr_i == `PWR_SETUP_ADDR) begin
      nxt_rdata = pwr_reg_ff;
    end
    if (mask_op_i) begin
      unique case (mask_op_num_i)
        `MASK_MOD0_NUM: nxt_mask[15:0] = mask_op_data_i; // R5 R6
        `MASK_MOD1_NUM: nxt_mask[31:16] = mask_op_data_i; // R5 R6
        `PER0_NUM: nxt_ival0 = mask_op_data_i; // R9
        `PER1_NUM: nxt_ival1 = mask_op_data_i; // R9
        default: ;
      endcase
    end
  end

  // Masks start all set and intervals zero, so no input or periodic interrupt fires
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tb_reg_ff <= `TB_RESET;
      pwr_reg_ff <= `PWR_RESET;
      rdata_ff <= 16'h0000;
      mask_ff <= `MASK_RESET; // R4
      ival0_ff <= 16'h0000; // R9
      ival1_ff <= 16'h0000;
    end else begin
      tb_reg_ff <= nxt_tb_reg;
      pwr_reg_ff <= nxt_pwr_reg;
      rdata_ff <= nxt_rdata;
      mask_ff <= nxt_mask;
      ival0_ff <= nxt_ival0;
      ival1_ff <= nxt_ival1;
    end
  end

  // Code 02 is honoured only where the fast base exists
  always_comb begin
    unique case (tb_reg_ff[`TB_FIELD_MSB:0])
      `TB_CODE_1MS: unit = TB_1MS; // R11
      `TB_CODE_100US: unit = (FAST_TB_EN != 0) ? TB_100US : TB_10MS;
      default: unit = TB_10MS; // R11
    endcase
  end

  // Fine tick divider and millisecond prescaler
  logic [15:0] div_ff, nxt_div;
  logic tick_ff, nxt_tick;
  logic [6:0] ms_pre_ff, nxt_ms_pre;
  logic ms_tick_ff, nxt_ms_tick;

  always_comb begin
    nxt_div = div_ff + 16'h0001;
    nxt_tick = 1'b0;
    nxt_ms_pre = ms_pre_ff;
    nxt_ms_tick = 1'b0;
    if (div_ff >= 16'(FINE_TICK_CYC - 1)) begin
      nxt_div = 16'h0000;
      nxt_tick = 1'b1;
    end
    if (tick_ff) begin
      if (ms_pre_ff >= `TICKS_1MS - 7'h01) begin
        nxt_ms_pre = 7'h00;
        nxt_ms_tick = 1'b1;
      end else begin
        nxt_ms_pre = ms_pre_ff + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 16'h0000;
      tick_ff <= 1'b0;
      ms_pre_ff <= 7'h00;
      ms_tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
      ms_pre_ff <= nxt_ms_pre;
      ms_tick_ff <= nxt_ms_tick;
    end
  end

  // Two periodic timers; a zero interval keeps a timer stopped
  logic [1:0] per_fire;
  logic [15:0] ival [2];
  assign ival[0] = ival0_ff;
  assign ival[1] = ival1_ff;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_per
      periodic_timer u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .fine_tick_i(tick_ff),
        .unit_i(unit),
        .interval_i(ival[g]),
        .run_i(ival[g] != 16'h0000), // R9
        .fire_o(per_fire[g])
      );
    end
  endgenerate

  // Power loss: default detection time plus delay, fired once per loss
  logic [7:0] pwr_ms_ff, nxt_pwr_ms;
  logic pwr_done_ff, nxt_pwr_done;
  logic pwr_fire;
  logic [7:0] dly;

  always_comb begin
    dly = pwr_reg_ff[`PWR_DLY_MSB:0];
    if (dly > `PWR_DLY_MAX) begin
      dly = `PWR_DLY_MAX; // R21
    end
    nxt_pwr_ms = pwr_ms_ff;
    nxt_pwr_done = pwr_done_ff;
    pwr_fire = 1'b0;
    if (!pwr_s || !pwr_reg_ff[`PWR_EN_BIT]) begin // R21
      nxt_pwr_ms = 8'h00;
      nxt_pwr_done = 1'b0;
    end else if (!pwr_done_ff) begin
      if (pwr_ms_ff >= 8'(PWR_DEFAULT_MS) + dly) begin
        pwr_fire = !duplex_s; // R13 R17
        nxt_pwr_done = 1'b1;
      end else if (ms_tick_ff) begin
        nxt_pwr_ms = pwr_ms_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ms_ff <= 8'h00;
      pwr_done_ff <= 1'b0;
    end else begin
      pwr_ms_ff <= nxt_pwr_ms;
      pwr_done_ff <= nxt_pwr_done;
    end
  end

  // Requests collected per task number, so sources sharing a number meet
  logic [255:0] req;
  always_comb begin
    req = '0;
    for (int i = 0; i < `IO_INPUTS; i++) begin
      if (io_s[i] && !io_prev[i] && !mask_ff[i]) begin // R2 R6
        req[`IO_TASK_BASE + 8'(i)] = 1'b1; // R3 R18
      end
    end
    if (per_fire[0]) begin
      req[`PER0_TASK] = 1'b1; // R8
    end
    if (per_fire[1]) begin
      req[`PER1_TASK] = 1'b1; // R8
    end
    if (ext_v_s && !ext_v_prev &&
        ext_s.slot <= 3'(MAX_SLOT)) begin // R16
      req[ext_s.num] = 1'b1; // R15 R18
    end
    if (duplex_s) begin
      req = '0; // R17
    end
  end

  // Dispatch: pending set, lowest number first, one task at a time
  disp_state_e state_ff, nxt_state;
  logic [255:0] pend_ff, nxt_pend;
  logic [7:0] sel_ff, nxt_sel;
  logic [7:0] low;
  logic tbl_hit;
  task_cmd_s cmd_ff, nxt_cmd;
  logic busy_ff, nxt_busy;
  logic fatal_ff, nxt_fatal;
  logic [7:0] ftask_ff, nxt_ftask;

  task_table_mem u_table (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .we_i(task_tbl_we_i),
    .waddr_i(task_tbl_addr_i),
    .wbit_i(task_tbl_bit_i),
    .raddr_i(sel_ff),
    .rdata_o(tbl_hit)
  );

  always_comb begin
    low = 8'h00;
    for (int i = 255; i >= 0; i--) begin
      if (pend_ff[i]) begin
        low = 8'(i);
      end
    end
    nxt_state = state_ff;
    nxt_pend = pend_ff;
    nxt_sel = sel_ff;
    nxt_cmd = '{start: 1'b0, abort: 1'b0, num: cmd_ff.num};
    nxt_fatal = fatal_ff;
    nxt_ftask = ftask_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (|pend_ff && !duplex_s) begin // R1 R20
          nxt_sel = low;
          nxt_pend[low] = 1'b0;
          nxt_state = ST_LOOK;
        end
      end
      ST_LOOK: nxt_state = ST_CHECK;
      ST_CHECK: begin
        if (tbl_hit) begin
          nxt_cmd.start = 1'b1; // R1
          nxt_cmd.num = sel_ff;
          nxt_state = ST_RUN;
        end else begin
          nxt_fatal = 1'b1; // R7
          nxt_ftask = sel_ff;
          nxt_state = ST_HALT; // R7
        end
      end
      ST_RUN: begin
        if (task_done_i) begin
          nxt_state = ST_IDLE; // R20
        end
      end
      ST_HALT: ;
    endcase
    // Power loss overrides everything but a halt or duplex mode; the aborted task is not resumed
    if (pwr_fire && state_ff != ST_HALT) begin
      nxt_cmd.abort = (state_ff == ST_RUN); // R19
      nxt_pend = '0; // R19
      nxt_sel = `PWR_TASK; // R13
      nxt_state = ST_LOOK;
    end
    // New requests are OR-ed last so a set beats the dispatch clear
    if (state_ff != ST_HALT) begin
      nxt_pend = nxt_pend | req; // R20
    end
    nxt_busy = (nxt_state != ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      pend_ff <= '0;
      sel_ff <= 8'h00;
      cmd_ff <= '0;
      busy_ff <= 1'b0;
      fatal_ff <= 1'b0;
      ftask_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      pend_ff <= nxt_pend;
      sel_ff <= nxt_sel;
      cmd_ff <= nxt_cmd;
      busy_ff <= nxt_busy;
      fatal_ff <= nxt_fatal;
      ftask_ff <= nxt_ftask;
    end
  end

  assign cfg_rdata_o = rdata_ff;
  assign task_cmd_o = cmd_ff;
  assign busy_o = busy_ff;
  assign fatal_error_o = fatal_ff;
  assign fatal_task_o = ftask_ff;

endmodule : plc_interrupt_task_dispatcher

// [tb/dispatch_asserts.sv]
// Port checker for the interrupt task dispatcher.
// Assumes binding to plc_interrupt_task_dispatcher on its clock.
`timescale 1ns/10ps
module dispatch_asserts
  import plc_dispatch_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [15:0] cfg_rdata_o,
  input wire logic task_done_i,
  input wire logic duplex_mode_i,
  input wire task_cmd_s task_cmd_o,
  input wire logic busy_o,
  input wire logic fatal_error_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_start_pulse: assert property (task_cmd_o.start |=> !task_cmd_o.start)
    else $error("start longer than one cycle");
  chk_start_busy: assert property (task_cmd_o.start |-> busy_o)
    else $error("start while not busy");
  chk_busy_start: assert property ($rose(busy_o) |-> ##[1:4]
    (task_cmd_o.start || task_cmd_o.abort || fatal_error_o))
    else $error("busy without start");
  chk_fatal_sticky: assert property (fatal_error_o |=> fatal_error_o)
    else $error("fatal flag dropped");
  chk_halt_quiet: assert property (fatal_error_o |-> !task_cmd_o.start)
    else $error("start after fatal");
  // A pending request may follow, but only through an idle cycle
  chk_done_idle: assert property (task_done_i && busy_o &&
    !fatal_error_o && !task_cmd_o.start |=> !busy_o)
    else $error("busy held after done");
  chk_num_hold: assert property (task_cmd_o.start ||
    $stable(task_cmd_o.num))
    else $error("task number moved without start");
  chk_duplex_off: assert property (duplex_mode_i[*6] |->
    !task_cmd_o.start)
    else $error("start in duplex mode");
  chk_unmapped_zero: assert property (!($past(cfg_addr_i) inside
    {8'hC3, 8'hE1}) |-> cfg_rdata_o == 16'h0000)
    else $error("unmapped word read nonzero");
  chk_abort_busy: assert property (task_cmd_o.abort |-> busy_o)
    else $error("abort while idle");

  cov_start: cover property (task_cmd_o.start);
  cov_abort: cover property (task_cmd_o.abort ##[1:5] task_cmd_o.start);
  cov_fatal: cover property ($rose(fatal_error_o));
endmodule : dispatch_asserts

bind plc_interrupt_task_dispatcher dispatch_asserts chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_addr_i(cfg_addr_i),
  .cfg_rdata_o(cfg_rdata_o), .task_done_i(task_done_i),
  .duplex_mode_i(duplex_mode_i), .task_cmd_o(task_cmd_o),
  .busy_o(busy_o), .fatal_error_o(fatal_error_o));

// [tb/rack_module_model.sv]
// Model of the input modules and rack units that raise requests.
// Assumes calls from the bench; drives on the falling clock edge.
`timescale 1ns/10ps
module rack_module_model
  import plc_dispatch_pkg::*;
(
  input wire logic clk_i,
  output logic [31:0] io_irq_o,
  output logic ext_valid_o,
  output ext_req_s ext_o
);
  // Idle lines; the request bus starts undriven-like, all ones
  initial begin
    io_irq_o = 32'h00000000;
    ext_valid_o = 1'b0;
    ext_o = 11'h7FF;
  end
  // Held four cycles so the two-flop sync always sees the edge
  task automatic pulse_io(input int idx);
    @(negedge clk_i) io_irq_o[idx] = 1'b1;
    repeat (4) @(negedge clk_i);
    io_irq_o[idx] = 1'b0;
  endtask : pulse_io
  // Word parked three cycles before valid; inverted once released
  task automatic request(input logic [2:0] slot, input logic [7:0] num);
    @(negedge clk_i) ext_o = {slot, num};
    repeat (3) @(negedge clk_i);
    ext_valid_o = 1'b1;
    repeat (4) @(negedge clk_i);
    ext_valid_o = 1'b0;
    ext_o = ~{slot, num};
  endtask : request
endmodule : rack_module_model

// [tb/tb_top.sv]
// Self-checking bench for the interrupt task dispatcher.
// Assumes the rack model and checker; bench plays the task engine.
`timescale 1ns/10ps
module tb_top;
  import plc_dispatch_pkg::*;
  logic clk_i, rst_n_i, cfg_we, mop, twe, tbit, pf, dup, done;
  logic [7:0] cfg_addr, mnum, taddr, na, nb, k, k2, tsk, fatal_task;
  logic [15:0] cfg_wdata, cfg_rdata, mdata;
  logic [31:0] io, r;
  logic ev, busy, fatal;
  ext_req_s ext;
  task_cmd_s cmd;
  int seed, errors, total_checks, cyc, t0, t1, n, cnt;

  // Short fine tick and power default keep the run brief
  plc_interrupt_task_dispatcher #(.FINE_TICK_CYC(10),
    .PWR_DEFAULT_MS(1)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_we_i(cfg_we),
    .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata),
    .cfg_rdata_o(cfg_rdata), .mask_op_i(mop), .mask_op_num_i(mnum),
    .mask_op_data_i(mdata), .task_tbl_we_i(twe),
    .task_tbl_addr_i(taddr), .task_tbl_bit_i(tbit), .io_irq_i(io),
    .ext_req_valid_i(ev), .ext_req_i(ext), .power_fail_i(pf),
    .duplex_mode_i(dup), .task_done_i(done), .task_cmd_o(cmd),
    .busy_o(busy), .fatal_error_o(fatal), .fatal_task_o(fatal_task));
  rack_module_model pm (.clk_i(clk_i), .io_irq_o(io),
    .ext_valid_o(ev), .ext_o(ext));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  function automatic logic [7:0] io_task(input int m, input logic [7:0] i);
    return 8'd100 + 8'(16 * m) + i;
  endfunction : io_task
  function automatic int period(input int code, input int c);
    return c * (code == 0 ? 100 : (code == 1 ? 10 : 1)) * 10;
  endfunction : period

  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // One-cycle strobes for the setup, mask and task table ports
  task automatic cfg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i) {cfg_we, cfg_addr, cfg_wdata} = {1'b1, a, d};
    @(negedge clk_i) cfg_we = 1'b0;
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk_i) cfg_addr = a;
    repeat (2) @(negedge clk_i);
    check("setup word", cfg_rdata, e);
  endtask : cfg_rd
  task automatic mask_op(input logic [7:0] m, input logic [15:0] d);
    @(negedge clk_i) {mop, mnum, mdata} = {1'b1, m, d};
    @(negedge clk_i) mop = 1'b0;
  endtask : mask_op
  task automatic tbl(input logic [7:0] a, input logic b);
    @(negedge clk_i) {twe, taddr, tbit} = {1'b1, a, b};
    @(negedge clk_i) twe = 1'b0;
  endtask : tbl
  task automatic expect_start(input int lim, input logic [7:0] e);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (cmd.start !== 1'b1 && n < lim);
    t0 = cyc;
    check("start", {15'h0000, cmd.start}, 16'h0001);
    check("task number", {8'h00, cmd.num}, {8'h00, e});
  endtask : expect_start
  task automatic quiet(input int c);
    repeat (c) begin
      @(negedge clk_i);
      if (cmd.start !== 1'b0) check("no start", 16'h0001, 16'h0000);
    end
  endtask : quiet
  task automatic finish_task();
    @(negedge clk_i) done = 1'b1;
    @(negedge clk_i) done = 1'b0;
  endtask : finish_task
  task automatic io_go(input int i, input logic [7:0] e);
    fork pm.pulse_io(i); expect_start(60, e); join
    finish_task();
  endtask : io_go
  task automatic ext_go(input logic [2:0] s, input logic [7:0] e);
    fork pm.request(s, e); expect_start(60, e); join
  endtask : ext_go

  // Watchdog well beyond the expected run of some 5000 cycles
  initial begin
    #600000;
    errors++;
    report_and_stop();
  end

  initial begin
    {clk_i, rst_n_i, cfg_we, mop, twe, tbit, pf, dup, done} = 9'h000;
    {cfg_addr, mnum, taddr, cfg_wdata, mdata} = 56'h0;
    seed = 3575;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    cfg_rd(8'hC3, 16'h0000);
    cfg_rd(8'h10, 16'h0000);
    r = $random(seed);
    na = 8'h04 + {2'b00, r[5:0]};
    nb = 8'h44 + {3'b000, r[12:8]};
    k = {4'h0, r[19:16]};
    k2 = {4'h0, k[3:0] + 4'h1};
    tbl(8'd1, 1'b1);
    tbl(8'd2, 1'b1);
    tbl(8'd3, 1'b1);
    tbl(8'd103, 1'b1);
    tbl(na, 1'b1);
    tbl(nb, 1'b1);
    tbl(io_task(1, k), 1'b1);
    // Inputs stay off until masks are opened; one mask bit per input
    fork pm.pulse_io(3); quiet(30); join
    mask_op(8'h00, 16'hFFF7);
    fork pm.pulse_io(2); quiet(30); join
    io_go(3, io_task(0, 8'd3));
    mask_op(8'h01, ~(16'h0001 << k));
    io_go(16 + k, io_task(1, k));
    fork pm.request(3'd5, na); quiet(40); join
    ext_go(3'd4, na);
    finish_task();
    // Requests during a task wait, then go lowest number first
    ext_go(3'd0, nb);
    fork pm.request(3'd1, na); pm.pulse_io(3); join
    quiet(20);
    finish_task();
    expect_start(40, na);
    finish_task();
    expect_start(40, 8'd103);
    finish_task();
    ext_go(3'd2, 8'h02);
    finish_task();
    // Each time base code, measured between two starts
    for (int code = 0; code < 3; code++) begin
      cnt = (code == 0) ? 1 : 2 + (r[24 + code] ? 1 : 0);
      cfg_wr(8'hC3, 16'(code));
      cfg_rd(8'hC3, 16'(code));
      tsk = 8'd2 + 8'(code % 2);
      mask_op(8'h04 + 8'(code % 2), 16'(cnt));
      expect_start(period(code, cnt) + 60, tsk);
      t1 = t0;
      finish_task();
      expect_start(period(code, cnt) + 60, tsk);
      check("interval", 16'(t0 - t1), 16'(period(code, cnt)));
      finish_task();
      mask_op(8'h04 + 8'(code % 2), 16'h0000);
      quiet(period(code, cnt) + 60);
    end
    dup = 1'b1;
    repeat (6) @(negedge clk_i);
    fork pm.request(3'd0, na); quiet(40); join
    dup = 1'b0;
    repeat (6) @(negedge clk_i);
    // Power loss with one ms of delay aborts the running task
    cfg_wr(8'hE1, 16'h8001);
    cfg_rd(8'hE1, 16'h8001);
    ext_go(3'd0, nb);
    @(negedge clk_i) pf = 1'b1;
    n = cyc;
    for (int w = 0; w < 800 && cmd.abort !== 1'b1; w++) @(negedge clk_i);
    check("abort", {15'h0000, cmd.abort}, 16'h0001);
    // Two ms counted in ms ticks, so the first tick may come early
    t1 = cyc - n;
    check("power delay", {15'h0000, t1 >= 100 && t1 <= 210}, 16'h0001);
    expect_start(10, 8'd1);
    pf = 1'b0;
    // Power task ends far inside its remaining budget
    finish_task();
    quiet(60);
    check("busy", {15'h0000, busy}, 16'h0000);
    // Enabled input with no task halts dispatch
    tbl(io_task(1, k2), 1'b0);
    mask_op(8'h01, ~(16'h0001 << k2));
    pm.pulse_io(16 + k2);
    repeat (10) @(negedge clk_i);
    check("fatal", {15'h0000, fatal}, 16'h0001);
    check("fatal task", {8'h00, fatal_task}, {8'h00, io_task(1, k2)});
    fork pm.request(3'd0, na); quiet(40); join
    report_and_stop();
  end
endmodule : tb_top
